/* File: shared/bscan_pkg.sv */
package bscan_pkg;

    // ------------------------------------------------------------
    // chain geometry
    // ------------------------------------------------------------
    localparam int CHAIN_LEN = 40;            // boundary_cell_chain length
    localparam int CTRL_W = 11;               // run_test_control width
    localparam int PORT_W = 8;                // pins per port

    // cell positions inside the chain
    localparam logic [5:0] ONE_OE_POS = 6'h27;   // port_one_output_enable
    localparam logic [5:0] TWO_OE_POS = 6'h26;   // port_two_output_enable
    localparam logic [5:0] CTRL_CELL_LSB = 6'h20; // control cells 39..32
    localparam logic [5:0] ONE_IN_LSB = 6'h18;   // port one input cells
    localparam logic [5:0] TWO_IN_LSB = 6'h10;   // port two input cells
    localparam logic [5:0] ONE_OUT_LSB = 6'h08;  // port one output cells
    localparam logic [5:0] TWO_OUT_LSB = 6'h00;  // port two output cells

    // run_test_control fields
    localparam int OP_LSB = 0;                // opcode bits 2..0
    localparam int MASK_LSB = 3;              // mask bits 10..3
    localparam logic [1:0] OPL_SAMPLE = 2'h0; // X00
    localparam logic [1:0] OPL_PATTERN = 2'h1; // X01
    localparam logic [1:0] OPL_SIG16 = 2'h2;  // X10
    localparam logic [2:0] OP_SIG_PAT = 3'h3; // 011
    localparam logic [2:0] OP_SIG_CNT = 3'h7; // 111

    // feedback taps, maximal length
    localparam logic [15:0] TAPS16 = 16'hB400;
    localparam logic [7:0] TAPS8 = 8'hB8;

    // reset and capture values
    localparam logic [CHAIN_LEN-1:0] CHAIN_RST = 40'h00_0000_0000;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    localparam logic BYPASS_CAPTURE = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // decoded instruction, delivered by the tap controller
    typedef enum logic [2:0] {
        INSTR_BYPASS = 3'h0,
        INSTR_READ = 3'h1,
        INSTR_SELF_TEST = 3'h2,
        INSTR_TOGGLE = 3'h3,
        INSTR_CTRL_SCAN = 3'h4,
        INSTR_RUN_TEST = 3'h5
    } instr_t;

    // operation chosen by run_test_control
    typedef enum logic [2:0] {
        MODE_SAMPLE = 3'h0,
        MODE_PATTERN = 3'h1,
        MODE_SIG16 = 3'h2,
        MODE_SIG_PAT = 3'h3,
        MODE_SIG_CNT = 3'h4
    } run_mode_t;

    // tap controller state flags, one tck domain
    typedef struct packed {
        logic captureDr;
        logic shiftDr;
        logic updateDr;
        logic runTestIdle;
        logic tdi;
    } tap_step_t;

    // one byte per port
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
    } port_pins_t;

endpackage

/* File: hdl/bscan_run_test.sv */
`timescale 1ns/10ps
// Contract
// - boundary read: chain unchanged at capture
// - self test: cells capture their complement
// - toggle: bypass captures 0, outputs toggle
// - toggle: input cells held, pins ignored
// - control scan: control register unchanged at capture
// - decode low three control bits into operations
// - operate only in run test idle
// - control cells excluded, enables still steer outputs
// - operate only when exactly one direction enabled
// - control bits 10..3 mask source inputs in signature modes; sample mode captures pins unmasked
// - masked input ignored, unmasked input compressed
// - sample mode captures inputs, toggles outputs
// - pattern mode runs sixteen bit sequence
// - all zero seed locks pattern register
// - sixteen bit signature, output latches constant
// - eight bit signature plus eight bit pattern
// - eight bit signature plus sixteen bit count
// - sample on tck rise, drive on fall
module bscan_run_test (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic tck,
    input wire bscan_pkg::instr_t instr,
    input wire bscan_pkg::tap_step_t tapStep,
    input wire bscan_pkg::port_pins_t pinIn,
    output logic [7:0] pinOutOne,
    output logic [7:0] pinOutTwo,
    output logic [7:0] pinOeOne,
    output logic [7:0] pinOeTwo,
    output bscan_pkg::port_pins_t toCore,
    output logic tdo,
    output logic tdoEn,
    output logic coreTestMode,
    output logic coreRunActive
);

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    // rising tck edge: shift stages and pin sampling
    typedef struct packed {
        logic [bscan_pkg::CHAIN_LEN-1:0] chain;   // shift stages
        logic [bscan_pkg::CTRL_W-1:0] ctrlShift;  // control shift stage
        logic bypass;                             // single bit path
        bscan_pkg::port_pins_t pinMeta;           // first sync stage
        bscan_pkg::port_pins_t pinSync;           // second sync stage
    } rise_t;

    // falling tck edge: shadow latches and everything at the pins
    typedef struct packed {
        logic [bscan_pkg::CHAIN_LEN-1:0] shadow;
        logic [bscan_pkg::CTRL_W-1:0] ctrl;       // run_test_control
        logic tdo;
        logic tdoEn;
        logic [7:0] outOne;
        logic [7:0] outTwo;
        logic [7:0] oeOne;
        logic [7:0] oeTwo;
        bscan_pkg::port_pins_t toCore;
        logic testMode;                           // cells own the pins
        logic runActive;                          // operation running
    } fall_t;

    // core clock side of the crossing
    typedef struct packed {
        logic testMeta;
        logic testSync;
        logic runMeta;
        logic runSync;
    } core_t;

    // ------------------------------------------------------------
    // reset release, two flops per domain
    // ------------------------------------------------------------
    logic [1:0] coreRstPipe;   // core_clk copy of rstn
    logic [1:0] tckRstPipe;    // tck copy of rstn
    logic coreRstN;
    logic tckRstN;

    // release is synchronous, assertion is immediate
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            coreRstPipe <= 2'h0;
        end else begin
            coreRstPipe <= {coreRstPipe[0], 1'b1};
        end
    end

    // tck may stop; release waits for its edges
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            tckRstPipe <= 2'h0;
        end else begin
            tckRstPipe <= {tckRstPipe[0], 1'b1};
        end
    end

    assign coreRstN = coreRstPipe[1];
    assign tckRstN = tckRstPipe[1];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // fibonacci step; zero seed locks
    function automatic logic [15:0] step16(input logic [15:0] s);
        step16 = {s[14:0], ^(s & bscan_pkg::TAPS16)};
    endfunction

    function automatic logic [7:0] step8(input logic [7:0] s);
        step8 = {s[6:0], ^(s & bscan_pkg::TAPS8)};
    endfunction

    // bits 1..0 pick 16-bit modes, bit 2 the pair
    function automatic bscan_pkg::run_mode_t decode(input logic [2:0] op);
        if (op[1:0] == bscan_pkg::OPL_SAMPLE) begin
            decode = bscan_pkg::MODE_SAMPLE;
        end else if (op[1:0] == bscan_pkg::OPL_PATTERN) begin
            decode = bscan_pkg::MODE_PATTERN;
        end else if (op[1:0] == bscan_pkg::OPL_SIG16) begin
            decode = bscan_pkg::MODE_SIG16;
        end else if (op == bscan_pkg::OP_SIG_PAT) begin
            decode = bscan_pkg::MODE_SIG_PAT;
        end else begin
            decode = bscan_pkg::MODE_SIG_CNT;
        end
    endfunction

    // ------------------------------------------------------------
    // direction and selection
    // ------------------------------------------------------------
    rise_t r;
    rise_t next_r;
    fall_t f;
    fall_t next_f;
    core_t c;
    core_t next_c;

    logic dirOk;              // exactly one port enabled
    logic oneDrives;          // port one outputs active (enable low)
    logic [5:0] inLsb;        // selected input cells
    logic [5:0] outLsb;       // selected output cells
    logic [5:0] oppLsb;       // opposite output cells
    logic [7:0] srcPins;      // synchronised source port pins
    logic [7:0] maskedPins;   // source pins after masking
    logic [7:0] mask;         // one bit per source pin
    logic runOn;              // selected operation may step
    logic toggleOn;           // toggle instruction may step
    bscan_pkg::run_mode_t mode;

    // enable cells read from the latches
    always_comb begin
        dirOk = f.shadow[bscan_pkg::ONE_OE_POS]
            != f.shadow[bscan_pkg::TWO_OE_POS];
        oneDrives = ~f.shadow[bscan_pkg::ONE_OE_POS];
        // mirrored: source port feeds, other drives
        inLsb = oneDrives ? bscan_pkg::TWO_IN_LSB
            : bscan_pkg::ONE_IN_LSB;
        outLsb = oneDrives ? bscan_pkg::ONE_OUT_LSB
            : bscan_pkg::TWO_OUT_LSB;
        oppLsb = oneDrives ? bscan_pkg::TWO_OUT_LSB
            : bscan_pkg::ONE_OUT_LSB;
        srcPins = oneDrives ? r.pinSync.two : r.pinSync.one;
        // bit 10 masks pin eight, bit 3 pin one
        mask = f.ctrl[bscan_pkg::MASK_LSB +: 8];
        maskedPins = srcPins & ~mask;
        mode = decode(f.ctrl[bscan_pkg::OP_LSB +: 3]);
        runOn = (instr == bscan_pkg::INSTR_RUN_TEST)
            && tapStep.runTestIdle && dirOk;
        toggleOn = (instr == bscan_pkg::INSTR_TOGGLE)
            && tapStep.runTestIdle && dirOk;
    end

    // ------------------------------------------------------------
    // rising edge: capture, shift, run operations
    // ------------------------------------------------------------
    // control cells 39..32 never step
    always_comb begin
        next_r = r;
        // pins pass two flops first
        next_r.pinMeta = pinIn;
        next_r.pinSync = r.pinMeta;
        if (tapStep.captureDr) begin
            unique case (instr)
                bscan_pkg::INSTR_READ: begin
                    next_r.chain = r.chain;
                end
                bscan_pkg::INSTR_CTRL_SCAN: begin
                    next_r.ctrlShift = r.ctrlShift;
                end
                bscan_pkg::INSTR_SELF_TEST: begin
                    // complement proves both halves
                    next_r.chain = ~f.shadow;
                end
                default: begin
                    next_r.bypass = bscan_pkg::BYPASS_CAPTURE;
                end
            endcase
        end else if (tapStep.shiftDr) begin
            unique case (instr)
                bscan_pkg::INSTR_READ,
                bscan_pkg::INSTR_SELF_TEST: begin
                    next_r.chain = {tapStep.tdi,
                        r.chain[bscan_pkg::CHAIN_LEN-1:1]};
                end
                bscan_pkg::INSTR_CTRL_SCAN: begin
                    next_r.ctrlShift = {tapStep.tdi,
                        r.ctrlShift[bscan_pkg::CTRL_W-1:1]};
                end
                default: begin
                    next_r.bypass = tapStep.tdi;
                end
            endcase
        end else if (toggleOn) begin
            // inputs frozen, pins not sampled
            next_r.chain[outLsb +: 8] = ~r.chain[outLsb +: 8];
        end else if (runOn) begin
            unique case (mode)
                bscan_pkg::MODE_SAMPLE: begin
                    next_r.chain[inLsb +: 8] = srcPins;
                    next_r.chain[outLsb +: 8] =
                        ~r.chain[outLsb +: 8];
                end
                bscan_pkg::MODE_PATTERN: begin
                    {next_r.chain[outLsb +: 8],
                        next_r.chain[inLsb +: 8]} = step16(
                        {r.chain[outLsb +: 8], r.chain[inLsb +: 8]});
                end
                bscan_pkg::MODE_SIG16: begin
                    {next_r.chain[outLsb +: 8],
                        next_r.chain[inLsb +: 8]} = step16(
                        {r.chain[outLsb +: 8], r.chain[inLsb +: 8]})
                        ^ {8'h00, maskedPins};
                end
                bscan_pkg::MODE_SIG_PAT: begin
                    next_r.chain[inLsb +: 8] =
                        step8(r.chain[inLsb +: 8]) ^ maskedPins;
                    next_r.chain[outLsb +: 8] =
                        step8(r.chain[outLsb +: 8]);
                end
                bscan_pkg::MODE_SIG_CNT: begin
                    next_r.chain[inLsb +: 8] =
                        step8(r.chain[inLsb +: 8]) ^ maskedPins;
                    next_r.chain[outLsb +: 8] =
                        r.chain[outLsb +: 8] + 8'h01;
                    // low byte carry steps the high byte
                    if (r.chain[outLsb +: 8] == 8'hFF) begin
                        next_r.chain[oppLsb +: 8] =
                            r.chain[oppLsb +: 8] + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // falling edge: shadow latches, pins, tdo
    // ------------------------------------------------------------
    // outside changes on the fall only
    always_comb begin
        next_f = f;
        // tdo enabled during shift only
        next_f.tdoEn = tapStep.shiftDr;
        unique case (instr)
            bscan_pkg::INSTR_READ,
            bscan_pkg::INSTR_SELF_TEST: next_f.tdo = r.chain[0];
            bscan_pkg::INSTR_CTRL_SCAN: next_f.tdo = r.ctrlShift[0];
            default: next_f.tdo = r.bypass;
        endcase
        if (tapStep.updateDr) begin
            if (instr == bscan_pkg::INSTR_CTRL_SCAN) begin
                next_f.ctrl = r.ctrlShift;
            end else if (instr == bscan_pkg::INSTR_READ
                || instr == bscan_pkg::INSTR_SELF_TEST) begin
                next_f.shadow = r.chain;
            end
        end else if (toggleOn) begin
            next_f.shadow[outLsb +: 8] = r.chain[outLsb +: 8];
        end else if (runOn) begin
            // inputs reach the core in every mode
            next_f.shadow[inLsb +: 8] = r.chain[inLsb +: 8];
            // sixteen bit signature holds the outputs
            if (mode != bscan_pkg::MODE_SIG16) begin
                next_f.shadow[outLsb +: 8] =
                    r.chain[outLsb +: 8];
            end
            if (mode == bscan_pkg::MODE_SIG_CNT) begin
                next_f.shadow[oppLsb +: 8] = r.chain[oppLsb +: 8];
            end
        end
        // test mode needs one direction
        next_f.testMode = dirOk
            && (instr == bscan_pkg::INSTR_TOGGLE
            || instr == bscan_pkg::INSTR_RUN_TEST);
        next_f.runActive = runOn;
        next_f.outOne = next_f.shadow[bscan_pkg::ONE_OUT_LSB +: 8];
        next_f.outTwo = next_f.shadow[bscan_pkg::TWO_OUT_LSB +: 8];
        // enable cells steer pins, never count
        next_f.oeOne = {8{next_f.testMode
            && !next_f.shadow[bscan_pkg::ONE_OE_POS]}};
        next_f.oeTwo = {8{next_f.testMode
            && !next_f.shadow[bscan_pkg::TWO_OE_POS]}};
        next_f.toCore.one = next_f.shadow[bscan_pkg::ONE_IN_LSB +: 8];
        next_f.toCore.two = next_f.shadow[bscan_pkg::TWO_IN_LSB +: 8];
    end

    always_ff @(negedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // ------------------------------------------------------------
    // core clock side: levels cross through two flops
    // ------------------------------------------------------------
    always_comb begin
        next_c = c;
        next_c.testMeta = f.testMode;
        next_c.testSync = c.testMeta;
        next_c.runMeta = f.runActive;
        next_c.runSync = c.runMeta;
    end

    always_ff @(posedge core_clk or negedge coreRstN) begin
        if (!coreRstN) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign pinOutOne = f.outOne;
    assign pinOutTwo = f.outTwo;
    assign pinOeOne = f.oeOne;
    assign pinOeTwo = f.oeTwo;
    assign toCore = f.toCore;
    assign tdo = f.tdo;
    assign tdoEn = f.tdoEn;
    assign coreTestMode = c.testSync;
    assign coreRunActive = c.runSync;

endmodule

/* File: verif/bscan_run_test_chk.sv */
`timescale 1ns/10ps
module bscan_run_test_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic tck,
    input wire bscan_pkg::instr_t instr,
    input wire bscan_pkg::tap_step_t tapStep,
    input wire bscan_pkg::port_pins_t pinIn,
    input wire logic [7:0] pinOutOne,
    input wire logic [7:0] pinOutTwo,
    input wire logic [7:0] pinOeOne,
    input wire logic [7:0] pinOeTwo,
    input wire bscan_pkg::port_pins_t toCore,
    input wire logic tdo,
    input wire logic tdoEn,
    input wire logic coreTestMode,
    input wire logic coreRunActive
);
    // ------------------------------------------------------------
    // step sequences
    // ------------------------------------------------------------
    // rise with no update or step, steady instruction
    sequence s_quiet;
        ($stable(instr) && !tapStep.updateDr && !tapStep.runTestIdle)
            ##1 $stable(instr);
    endsequence
    // toggle step, port one drives
    sequence s_toggle_step;
        instr == bscan_pkg::INSTR_TOGGLE && tapStep.runTestIdle
            && pinOeOne == 8'hFF && pinOeTwo == 8'h00;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_pins_on_fall;
        @(posedge core_clk) disable iff (!rstn)
            !$stable({pinOutOne, pinOutTwo}) |-> !tck;
    endproperty
    property p_tdo_on_fall;
        @(posedge core_clk) disable iff (!rstn)
            !$stable({tdo, tdoEn}) |-> !tck;
    endproperty
    property p_hold_pins;
        @(posedge tck) disable iff (!rstn)
            s_quiet |-> $stable({pinOutOne, pinOutTwo});
    endproperty
    property p_hold_core;
        @(posedge tck) disable iff (!rstn) s_quiet |-> $stable(toCore);
    endproperty
    property p_hold_oe;
        @(posedge tck) disable iff (!rstn)
            s_quiet |-> $stable({pinOeOne, pinOeTwo});
    endproperty
    property p_tdoen_start;
        @(posedge tck) disable iff (!rstn)
            $rose(tdoEn) |-> $past(tapStep.captureDr) || $past(tapStep.shiftDr);
    endproperty
    property p_toggle;
        @(posedge tck) disable iff (!rstn)
            s_toggle_step |=> pinOutOne == ~$past(pinOutOne);
    endproperty
    property p_run_mode;
        @(posedge core_clk) disable iff (!rstn) coreRunActive |-> coreTestMode;
    endproperty
    property p_oe_whole;
        @(posedge core_clk) disable iff (!rstn)
            (pinOeOne == 8'h00 || pinOeOne == 8'hFF)
            && (pinOeTwo == 8'h00 || pinOeTwo == 8'hFF);
    endproperty
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_pins_on_fall: assert property (p_pins_on_fall)
        else $error("pins moved, tck high");
    a_tdo_on_fall: assert property (p_tdo_on_fall)
        else $error("tdo moved, tck high");
    a_hold_pins: assert property (p_hold_pins)
        else $error("pins moved idle");
    a_hold_core: assert property (p_hold_core)
        else $error("core moved idle");
    a_hold_oe: assert property (p_hold_oe)
        else $error("enables moved idle");
    a_tdoen_start: assert property (p_tdoen_start)
        else $error("tdo enabled, no scan");
    a_toggle: assert property (p_toggle)
        else $error("no toggle");
    a_run_mode: assert property (p_run_mode)
        else $error("stepping outside test mode");
    a_oe_whole: assert property (p_oe_whole)
        else $error("split enable");
endmodule

bind bscan_run_test bscan_run_test_chk bscan_run_test_chk_i (
    .core_clk(core_clk), .rstn(rstn), .tck(tck), .instr(instr),
    .tapStep(tapStep), .pinIn(pinIn), .pinOutOne(pinOutOne),
    .pinOutTwo(pinOutTwo), .pinOeOne(pinOeOne), .pinOeTwo(pinOeTwo),
    .toCore(toCore), .tdo(tdo), .tdoEn(tdoEn),
    .coreTestMode(coreTestMode), .coreRunActive(coreRunActive)
);

/* File: verif/tap_host.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// test controller model; tck rests low between frames
// ------------------------------------------------------------
module tap_host (
    output logic tck,
    output bscan_pkg::instr_t instr,
    output bscan_pkg::tap_step_t tapStep,
    input wire logic tdo
);
    // idle values from time zero
    initial begin
        tck = 1'b0;
        instr = bscan_pkg::INSTR_BYPASS;
        tapStep = '0;
    end
    // one tck cycle: flags {cap, shift, upd, idle}; tdo read before rise
    task automatic pulse(input logic [3:0] f, input logic d, output logic o);
        // tdi outside shift: inverse, not stale
        tapStep <= {f, f[2] ? d : ~tapStep.tdi};
        #40 o = tdo;
        #40 tck = 1'b1;
        #80 tck = 1'b0;
    endtask
    task automatic idle(input int n);
        logic o;
        repeat (n) pulse(4'h0, 1'b0, o);
    endtask
    // capture, shift n bits lsb first, then update
    task automatic scan(input bscan_pkg::instr_t ins, input int n,
                        input logic [39:0] din, output logic [39:0] dout);
        logic o;
        dout = '0;
        instr <= ins;
        pulse(4'h8, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            pulse(4'h4, din[i], o);
            dout[i] = o;
        end
        pulse(4'h2, 1'b0, o);
        pulse(4'h0, 1'b0, o);
    endtask
    // settle instruction one cycle, then n steps
    task automatic run(input bscan_pkg::instr_t ins, input int n);
        logic o;
        instr <= ins;
        idle(1);
        repeat (n) pulse(4'h1, 1'b0, o);
    endtask
endmodule

/* File: verif/test_boundary_scan_test_operations.sv */
`timescale 1ns/10ps
module test_boundary_scan_test_operations;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam bscan_pkg::instr_t RUN = bscan_pkg::INSTR_RUN_TEST;
    localparam bscan_pkg::instr_t TGL = bscan_pkg::INSTR_TOGGLE;
    logic core_clk;
    logic rstn;
    bscan_pkg::port_pins_t pinIn;
    logic tck;
    bscan_pkg::instr_t instr;
    bscan_pkg::tap_step_t tapStep;
    logic [7:0] pinOutOne, pinOutTwo, pinOeOne, pinOeTwo;
    bscan_pkg::port_pins_t toCore;
    logic tdo, tdoEn, coreTestMode, coreRunActive;
    int n_mismatch;
    int total_checks;
    // constant pins: sync delay cannot matter
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        pinIn = '{one: 8'h3C, two: 8'hA5};
        n_mismatch = 0;
        total_checks = 0;
    end
    always #2 core_clk = ~core_clk;
    bscan_run_test bscan_run_test_i (
        .core_clk(core_clk), .rstn(rstn), .tck(tck), .instr(instr),
        .tapStep(tapStep), .pinIn(pinIn), .pinOutOne(pinOutOne),
        .pinOutTwo(pinOutTwo), .pinOeOne(pinOeOne), .pinOeTwo(pinOeTwo),
        .toCore(toCore), .tdo(tdo), .tdoEn(tdoEn),
        .coreTestMode(coreTestMode), .coreRunActive(coreRunActive));
    tap_host tap_host_i (.tck(tck), .instr(instr), .tapStep(tapStep),
        .tdo(tdo));
    // ------------------------------------------------------------
    // model of the 16 selected cells {out, in}
    // ------------------------------------------------------------
    function automatic logic [15:0] f16(input logic [15:0] s);
        return {s[14:0], ^(s & bscan_pkg::TAPS16)};
    endfunction
    function automatic logic [7:0] f8(input logic [7:0] s);
        return {s[6:0], ^(s & bscan_pkg::TAPS8)};
    endfunction
    function automatic logic [15:0] nxt(input bscan_pkg::instr_t ins,
        input logic [10:0] c, input logic [15:0] s, input logic [7:0] p);
        logic [7:0] q;
        q = p & ~c[10:3];
        if (ins == TGL)
            return {~s[15:8], s[7:0]};
        else if (c[2:0] == bscan_pkg::OP_SIG_PAT)
            return {f8(s[15:8]), f8(s[7:0]) ^ q};
        else if (c[2:0] == bscan_pkg::OP_SIG_CNT)
            return {s[15:8] + 8'h01, f8(s[7:0]) ^ q};
        else if (c[1:0] == bscan_pkg::OPL_SAMPLE)
            return {~s[15:8], p};
        else if (c[1:0] == bscan_pkg::OPL_PATTERN)
            return f16(s);
        else
            return f16(s) ^ {8'h00, q};
    endfunction
    // ------------------------------------------------------------
    // compare and closing
    // ------------------------------------------------------------
    task automatic cmp(input logic [39:0] g, input logic [39:0] e,
                       input string m);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // load control register, read back
    task automatic set_ctrl(input logic [10:0] c);
        logic [39:0] d;
        tap_host_i.scan(bscan_pkg::INSTR_CTRL_SCAN, 11, {29'h0, c}, d);
        tap_host_i.scan(bscan_pkg::INSTR_CTRL_SCAN, 11, {29'h0, c}, d);
        cmp(d, {29'h0, c}, "control readback");
    endtask
    task automatic t_read_self;
        logic [39:0] s, d;
        s = 40'h5C_A5F0_1E69;
        tap_host_i.scan(bscan_pkg::INSTR_READ, 40, s, d);
        tap_host_i.scan(bscan_pkg::INSTR_READ, 40, s, d);
        cmp(d, s, "read");
        tap_host_i.scan(bscan_pkg::INSTR_SELF_TEST, 40, s, d);
        cmp(d, ~s, "self test");
    endtask
    // seed, run n steps, judge pins, core, chain
    task automatic run_check(input bscan_pkg::instr_t ins,
        input logic [10:0] c, input logic [1:0] dir, input logic [15:0] sd,
        input int n);
        logic [39:0] s, d;
        logic [15:0] e;
        logic [7:0] two;
        logic ok;
        ok = dir[1] ^ dir[0];
        e = sd;
        two = 8'h10;
        for (int i = 0; i < n; i++) begin
            // carry bumps the opposite byte
            if (ok && c[2:0] == bscan_pkg::OP_SIG_CNT && e[15:8] == 8'hFF)
                two = two + 8'h01;
            if (ok)
                e = nxt(ins, c, e, pinIn.two);
        end
        s = {dir, 14'h0, sd[7:0], sd[15:8], 8'h10};
        set_ctrl(c);
        tap_host_i.scan(bscan_pkg::INSTR_READ, 40, s, d);
        tap_host_i.run(ins, n);
        #10;
        cmp(40'(coreTestMode), 40'(ok), "test mode");
        cmp(40'(pinOeOne), ok ? 40'hFF : 40'h0, "enable one");
        cmp(40'(pinOeTwo), 40'h0, "enable two");
        cmp(40'(pinOutTwo), 40'(two), "pins two");
        if (ok) begin
            // sixteen bit signature holds output latches
            if (ins == RUN && c[1:0] == bscan_pkg::OPL_SIG16)
                cmp(40'(pinOutOne), 40'(sd[15:8]), "held pins");
            else
                cmp(40'(pinOutOne), 40'(e[15:8]), "pins");
            cmp(40'(toCore.two), 40'(e[7:0]), "core side");
        end
        tap_host_i.scan(bscan_pkg::INSTR_READ, 40, s, d);
        cmp(40'({d[15:8], d[23:16]}), 40'(e), "cells");
        cmp(40'(d[7:0]), 40'(two), "opposite");
    endtask
    // ------------------------------------------------------------
    // main and watchdog
    // ------------------------------------------------------------
    initial begin
        #1.3;
        tap_host_i.idle(2);
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        tap_host_i.idle(4);
        t_read_self();
        run_check(RUN, 11'h004, 2'b01, 16'h5A3C, 3);
        run_check(RUN, 11'h005, 2'b01, 16'hACE1, 5);
        run_check(RUN, 11'h001, 2'b01, 16'h0000, 4);
        run_check(RUN, 11'h786, 2'b01, 16'h1234, 5);
        run_check(RUN, 11'h003, 2'b01, 16'h9C21, 4);
        run_check(RUN, 11'h007, 2'b01, 16'hFE5A, 3);
        run_check(RUN, 11'h001, 2'b11, 16'h1111, 3);
        run_check(RUN, 11'h001, 2'b00, 16'h1111, 2);
        run_check(TGL, 11'h000, 2'b01, 16'h0F0F, 3);
        wrap_up();
    end
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
endmodule
